// ==== verilog/timer16_wave.sv ====
// 16-bit timer with clear-on-match and fast pwm waveform generation, apb slave
// How it works
// [R1] modes 4/12 clear counter on top match
// [R2] clear-on-match top unbuffered, late write wraps
// [R3] action 1 toggles wave A on match
// [R4] pin driven only when direction bit set
// [R5] toggle period two times prescale times top+1
// [R6] overflow flag on max to zero
// [R7] top register flag set at top
// [R8] fast pwm counts zero to top, restarts
// [R9] fast pwm tops: fixed, capture, compare A
// [R10] action 2/3 clear/set on match, opposite at zero
// [R11] fast pwm overflow and top flag at top
// [R12] fixed top masks high compare bits on write
// [R13] fast pwm capture top unbuffered
// [R14] compare A buffered, loaded at top
// [R15] fast pwm period prescale times top+1
// [R16] compare zero spikes, compare top constant
// [R17] action 1 toggles A only mode 15
// [R18] software keeps variable top at least three
// [R19] software keeps top above compare values
// [R20] compare flag set on every match
// [R21] action zero leaves wave register alone
// [R22] nonzero action routes wave to pin
// [R23] counting advances only on timer tick
`timescale 1ns/100ps
`default_nettype none
module timer16_wave (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// waveform pins, index 0 is channel A
	output logic [1:0] wave_pin,
	output logic [1:0] wave_pin_oe
);
	localparam int FLAG_W_L = timer16_pkg::FLAG_W;
	localparam int CTRL_WL = timer16_pkg::CTRL_W;
	logic rst_meta_b;
	logic rst_sync_b;
	timer16_pkg::ctrl_s ctrl;
	logic [15:0] counter_value;
	logic [15:0] capture_top_value;
	logic [15:0] compare_value [2];
	logic [15:0] compare_buf [2];
	logic [1:0] wave_out;
	logic [1:0] match;
	logic [1:0] cmp_wr;
	logic [1:0] output_action [2];
	logic [FLAG_W_L-1:0] flags;
	logic [9:0] div_count;
	logic [9:0] div_term;
	logic tick;
	logic block_match;
	logic wr_en;
	logic setup;
	logic cnt_wr;
	logic mode_ctc;
	logic mode_fast;
	logic mode_fixed;
	logic at_top;
	logic [15:0] top;
	logic [15:0] fixed_mask;
	logic [15:0] wr_value;
	logic [15:0] next_count;
	logic [FLAG_W_L-1:0] flag_set;
	logic [FLAG_W_L-1:0] flag_clr;
	logic mapped;
	logic [31:0] next_rdata;

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// apb: no wait states, pready raised in the first access phase cycle
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign cnt_wr = wr_en && (paddr == timer16_pkg::OFF_COUNT);
	assign cmp_wr[0] = wr_en && (paddr == timer16_pkg::OFF_CMP_A);
	assign cmp_wr[1] = wr_en && (paddr == timer16_pkg::OFF_CMP_B);

	always_comb begin
		mapped = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr)
			timer16_pkg::OFF_CTRL: next_rdata[CTRL_WL-1:0] = ctrl;
			timer16_pkg::OFF_COUNT: next_rdata[15:0] = counter_value;
			timer16_pkg::OFF_CMP_A: next_rdata[15:0] = compare_buf[0];
			timer16_pkg::OFF_CMP_B: next_rdata[15:0] = compare_buf[1];
			timer16_pkg::OFF_CAPTOP: next_rdata[15:0] = capture_top_value;
			timer16_pkg::OFF_FLAGS: next_rdata[FLAG_W_L-1:0] = flags;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl <= timer16_pkg::CTRL_RESET;
		end else if (wr_en && paddr == timer16_pkg::OFF_CTRL) begin
			ctrl <= pwdata[CTRL_WL-1:0];
		end
	end

	// prescaler: restarts whenever the count is reached or the timer stops
	always_comb begin
		case (ctrl.clock_sel)
			timer16_pkg::CLK_DIV_1: div_term = timer16_pkg::TERM_1;
			timer16_pkg::CLK_DIV_8: div_term = timer16_pkg::TERM_8;
			timer16_pkg::CLK_DIV_64: div_term = timer16_pkg::TERM_64;
			timer16_pkg::CLK_DIV_256: div_term = timer16_pkg::TERM_256;
			default: div_term = timer16_pkg::TERM_1024;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			div_count <= 10'h000;
			tick <= 1'b0;
		end else if (ctrl.clock_sel == timer16_pkg::CLK_STOP) begin
			div_count <= 10'h000;
			tick <= 1'b0;
		end else if (div_count >= div_term) begin
			div_count <= 10'h000;
			tick <= 1'b1; // R5 R15
		end else begin
			div_count <= div_count + 10'h001;
			tick <= 1'b0;
		end
	end

	// mode decode and top selection
	always_comb begin
		mode_ctc = 1'b0;
		mode_fast = 1'b0;
		mode_fixed = 1'b0;
		top = timer16_pkg::COUNT_MAX;
		fixed_mask = timer16_pkg::COUNT_MAX;
		case (ctrl.waveform_mode_select)
			timer16_pkg::MODE_CTC_A: begin
				mode_ctc = 1'b1;
				top = compare_value[0]; // R1
			end
			timer16_pkg::MODE_CTC_CAP: begin
				mode_ctc = 1'b1;
				top = capture_top_value; // R1 R2
			end
			timer16_pkg::MODE_FAST_8: begin
				mode_fast = 1'b1;
				mode_fixed = 1'b1;
				top = timer16_pkg::TOP_8; // R9
			end
			timer16_pkg::MODE_FAST_9: begin
				mode_fast = 1'b1;
				mode_fixed = 1'b1;
				top = timer16_pkg::TOP_9; // R9
			end
			timer16_pkg::MODE_FAST_10: begin
				mode_fast = 1'b1;
				mode_fixed = 1'b1;
				top = timer16_pkg::TOP_10; // R9
			end
			timer16_pkg::MODE_FAST_CAP: begin
				mode_fast = 1'b1;
				top = capture_top_value; // R9 R13
			end
			timer16_pkg::MODE_FAST_A: begin
				mode_fast = 1'b1;
				top = compare_value[0]; // R9
			end
			default: begin
				mode_ctc = 1'b0;
			end
		endcase
		if (mode_fixed) begin
			fixed_mask = top;
		end
	end

	// an exact equality check is why a top written below the count is missed
	assign at_top = (mode_ctc || mode_fast) && (counter_value == top); // R2 R13
	assign next_count = at_top ? timer16_pkg::COUNT_ZERO : counter_value + 16'h0001; // R1 R8
	assign wr_value = pwdata[15:0] & fixed_mask; // R12

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			counter_value <= timer16_pkg::COUNT_ZERO;
		end else if (cnt_wr) begin
			counter_value <= pwdata[15:0];
		end else if (tick) begin
			counter_value <= next_count; // R23
		end
	end

	// a counter write suppresses matches on the following tick
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			block_match <= 1'b0;
		end else if (cnt_wr) begin
			block_match <= 1'b1;
		end else if (tick) begin
			block_match <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			capture_top_value <= timer16_pkg::COUNT_ZERO;
		end else if (wr_en && paddr == timer16_pkg::OFF_CAPTOP) begin
			capture_top_value <= pwdata[15:0]; // R2 R13
		end
	end

	assign output_action[0] = ctrl.output_action_a;
	assign output_action[1] = ctrl.output_action_b;

	// per-channel compare storage, match and waveform register
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		assign match[ch] = tick && !block_match && (counter_value == compare_value[ch]); // R20

		always_ff @(posedge clk_sys or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				compare_buf[ch] <= timer16_pkg::COUNT_ZERO;
			end else if (cmp_wr[ch]) begin
				compare_buf[ch] <= wr_value; // R14
			end
		end

		// pwm loads only at top so a period never sees a half-updated compare
		always_ff @(posedge clk_sys or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				compare_value[ch] <= timer16_pkg::COUNT_ZERO;
			end else if (mode_fast) begin
				if (tick && at_top) begin
					compare_value[ch] <= compare_buf[ch]; // R14
				end
			end else if (cmp_wr[ch]) begin
				compare_value[ch] <= wr_value; // R2
			end
		end

		always_ff @(posedge clk_sys or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				wave_out[ch] <= 1'b0;
			end else if (mode_fast) begin
				case (output_action[ch])
					timer16_pkg::ACT_TOGGLE: begin
						if (ch == 0 && ctrl.waveform_mode_select == timer16_pkg::MODE_FAST_A && match[ch]) begin
							wave_out[ch] <= ~wave_out[ch]; // R17
						end
					end
					// top event wins so compare equal to top gives a steady level
					timer16_pkg::ACT_CLEAR: begin
						if (tick && at_top) begin
							wave_out[ch] <= 1'b1; // R10 R16
						end else if (match[ch]) begin
							wave_out[ch] <= 1'b0; // R10
						end
					end
					timer16_pkg::ACT_SET: begin
						if (tick && at_top) begin
							wave_out[ch] <= 1'b0; // R10 R16
						end else if (match[ch]) begin
							wave_out[ch] <= 1'b1; // R10
						end
					end
					default: begin
						wave_out[ch] <= wave_out[ch]; // R21
					end
				endcase
			end else if (match[ch]) begin
				case (output_action[ch])
					timer16_pkg::ACT_TOGGLE: wave_out[ch] <= ~wave_out[ch]; // R3 R5
					timer16_pkg::ACT_CLEAR: wave_out[ch] <= 1'b0;
					timer16_pkg::ACT_SET: wave_out[ch] <= 1'b1;
					default: wave_out[ch] <= wave_out[ch]; // R21
				endcase
			end
		end

		always_ff @(posedge clk_sys or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				wave_pin[ch] <= 1'b0;
				wave_pin_oe[ch] <= 1'b0;
			end else begin
				wave_pin[ch] <= (output_action[ch] != timer16_pkg::ACT_NONE) ? wave_out[ch] : ctrl.port_out[ch]; // R22
				wave_pin_oe[ch] <= ctrl.pin_direction[ch]; // R4
			end
		end
	end

	// status flags: write one to clear, a same-cycle set wins
	always_comb begin
		flag_set = '0;
		flag_set[timer16_pkg::FLAG_OVF] = tick && (mode_fast ? at_top : counter_value == timer16_pkg::COUNT_MAX); // R6 R11
		flag_set[timer16_pkg::FLAG_CMP_A] = match[0]; // R7 R11 R20
		flag_set[timer16_pkg::FLAG_CMP_B] = match[1]; // R20
		flag_set[timer16_pkg::FLAG_CAP] = tick && at_top && (ctrl.waveform_mode_select == timer16_pkg::MODE_CTC_CAP ||
			ctrl.waveform_mode_select == timer16_pkg::MODE_FAST_CAP); // R7 R11
		flag_clr = (wr_en && paddr == timer16_pkg::OFF_FLAGS) ? pwdata[FLAG_W_L-1:0] : '0;
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_b);

	AST_CTC_CLEAR: assert property (tick && mode_ctc && at_top && !cnt_wr |=> counter_value == 16'h0000) // R1
		else $error("counter not cleared at top in clear-on-match mode");
	AST_FAST_STEP: assert property (tick && mode_fast && !at_top && !cnt_wr |=> counter_value == $past(counter_value) + 16'h0001) // R8
		else $error("fast pwm counter did not step by one");
	AST_HOLD: assert property (!tick && !cnt_wr |=> $stable(counter_value)) // R23
		else $error("counter moved without a timer tick");
	AST_OVF_CTC: assert property (tick && mode_ctc && counter_value == 16'hFFFF |=> flags[0]) // R6
		else $error("overflow flag missed at wrap");
	AST_OVF_FAST: assert property (tick && mode_fast && at_top |=> flags[0] && counter_value == 16'h0000 || $past(cnt_wr)) // R11
		else $error("fast pwm top did not overflow and clear");
	AST_BUF_LOAD: assert property (tick && mode_fast && at_top |=> compare_value[0] == $past(compare_buf[0])) // R14
		else $error("compare A not loaded from buffer at top");
	AST_NO_EARLY_LOAD: assert property (mode_fast && !(tick && at_top) ##1 mode_fast |-> $stable(compare_value[0])) // R14
		else $error("compare A changed away from top");
	AST_CMP_FLAG: assert property (match[1] |=> flags[2]) // R20
		else $error("compare B flag not set on match");
	AST_CTC_TOGGLE: assert property (!mode_fast && match[0] && ctrl.output_action_a == 2'h1 |=> wave_out[0] != $past(wave_out[0])) // R3
		else $error("wave A did not toggle on match");
	AST_FAST_SET: assert property (mode_fast && tick && at_top && ctrl.output_action_a == 2'h2 |=> wave_out[0]) // R10
		else $error("non-inverting wave not set at top");
	AST_PIN_DIR: assert property ($changed(ctrl.pin_direction[0]) |=> wave_pin_oe[0] == $past(ctrl.pin_direction[0])) // R4
		else $error("pin enable does not follow direction");
	AST_ROUTE: assert property (ctrl.output_action_a != timer16_pkg::ACT_NONE |=> wave_pin[0] == $past(wave_out[0])) // R22
		else $error("wave A not routed to pin with nonzero action");
	AST_IDLE_ACT: assert property (ctrl.output_action_a == timer16_pkg::ACT_NONE |=> $stable(wave_out[0])) // R21
		else $error("wave A changed with output action zero");
	AST_CAP_TOP: assert property (tick && at_top && ctrl.waveform_mode_select == timer16_pkg::MODE_FAST_CAP
		|=> flags[timer16_pkg::FLAG_CAP] && flags[timer16_pkg::FLAG_OVF]) // R11
		else $error("capture and overflow flags not set at fast pwm top");
	AST_FAST_TOGGLE: assert property (match[0] && ctrl.waveform_mode_select == timer16_pkg::MODE_FAST_A
		&& ctrl.output_action_a == timer16_pkg::ACT_TOGGLE |=> wave_out[0] != $past(wave_out[0])) // R17
		else $error("wave A did not toggle on match in mode 15");
	AST_MASK: assert property (cmp_wr[1] && mode_fixed |=> (compare_buf[1] & ~$past(top)) == 16'h0000) // R12
		else $error("compare bits above fixed top not masked");
endmodule
`default_nettype wire

// ==== verilog/timer16_pkg.sv ====
// constants, register map and carrier types for the 16-bit waveform timer
package timer16_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_CMP_A = 8'h08;
	localparam logic [7:0] OFF_CMP_B = 8'h0C;
	localparam logic [7:0] OFF_CAPTOP = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	// status flag bit positions
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_A = 1;
	localparam int FLAG_CMP_B = 2;
	localparam int FLAG_CAP = 3;
	localparam int FLAG_W = 4;
	localparam int CTRL_W = 15;
	// waveform mode codes
	localparam logic [3:0] MODE_CTC_A = 4'h4;
	localparam logic [3:0] MODE_FAST_8 = 4'h5;
	localparam logic [3:0] MODE_FAST_9 = 4'h6;
	localparam logic [3:0] MODE_FAST_10 = 4'h7;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [3:0] MODE_FAST_CAP = 4'hE;
	localparam logic [3:0] MODE_FAST_A = 4'hF;
	// fixed top values and counter limits
	localparam logic [15:0] TOP_8 = 16'h00FF;
	localparam logic [15:0] TOP_9 = 16'h01FF;
	localparam logic [15:0] TOP_10 = 16'h03FF;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	// output action codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	// prescale terminal counts (factor minus one), select 0 stops the timer
	localparam logic [2:0] CLK_STOP = 3'h0;
	localparam logic [2:0] CLK_DIV_1 = 3'h1;
	localparam logic [2:0] CLK_DIV_8 = 3'h2;
	localparam logic [2:0] CLK_DIV_64 = 3'h3;
	localparam logic [2:0] CLK_DIV_256 = 3'h4;
	localparam logic [9:0] TERM_1 = 10'h000;
	localparam logic [9:0] TERM_8 = 10'h007;
	localparam logic [9:0] TERM_64 = 10'h03F;
	localparam logic [9:0] TERM_256 = 10'h0FF;
	localparam logic [9:0] TERM_1024 = 10'h3FF;

	typedef struct packed {
		logic [2:0] clock_sel;
		logic [1:0] port_out;
		logic [1:0] pin_direction;
		logic [1:0] output_action_b;
		logic [1:0] output_action_a;
		logic [3:0] waveform_mode_select;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '0;
endpackage

// ==== sim/wave_load.sv ====
// external load on the waveform pins: pull-down pads and pulse timing on channel A
`timescale 1ns/100ps
`default_nettype none
module wave_load (
	// clock
	input wire logic clk_sys,
	// pins from the timer
	input wire logic [1:0] wave_pin,
	input wire logic [1:0] wave_pin_oe,
	// pad levels and channel A timing in clocks
	output logic [1:0] pad,
	output logic [15:0] period,
	output logic [15:0] high_len,
	output logic [15:0] edges
);
	logic prev;
	logic [15:0] since_rise;
	// an undriven pad falls to the pull-down level, never keeps the last value
	assign pad = wave_pin & wave_pin_oe;
	initial begin
		prev = 1'b0;
		since_rise = 16'h0000;
		period = 16'h0000;
		high_len = 16'h0000;
		edges = 16'h0000;
	end
	always @(posedge clk_sys) begin
		prev <= pad[0];
		since_rise <= (pad[0] && !prev) ? 16'h0001 : since_rise + 16'h0001;
		if (pad[0] && !prev) begin
			period <= since_rise;
			edges <= edges + 16'h0001;
		end
		if (!pad[0] && prev) begin
			high_len <= since_rise;
		end
	end
endmodule
`default_nettype wire

// ==== sim/timer16_ctc_fast_pwm_tb.sv ====
// self-checking bench for the waveform timer: registers, clear-on-match and fast pwm waveforms
`timescale 1ns/100ps
`default_nettype none
module timer16_ctc_fast_pwm_tb;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] top;
		logic [15:0] cmp;
		logic [15:0] per;
		logic [15:0] hi;
		logic [3:0] flags;
	} wave_case_s;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] wave_pin;
	logic [1:0] wave_pin_oe;
	logic [1:0] pad;
	logic [15:0] period;
	logic [15:0] high_len;
	logic [15:0] edges;
	logic [15:0] edges_seen;
	logic [31:0] rdata;
	logic rerr;
	int error_cnt = 0;
	int checks_done = 0;
	// variable tops stay at least 3 and above every compare value
	wave_case_s cases [9] = '{
		'{16'h1114, 16'hFFFF, 16'h0003, 16'd8, 16'd4, 4'h6},
		'{16'h2114, 16'hFFFF, 16'h0003, 16'd64, 16'd32, 4'h6},
		'{16'h111C, 16'h0004, 16'h0001, 16'd10, 16'd5, 4'hE},
		'{16'h112E, 16'h0007, 16'h0002, 16'd8, 16'd3, 4'hF},
		'{16'h113E, 16'h0007, 16'h0002, 16'd8, 16'd5, 4'hF},
		'{16'h111F, 16'h0007, 16'h0003, 16'd8, 16'd4, 4'h7},
		'{16'h112E, 16'h0007, 16'h0000, 16'd8, 16'd1, 4'hF},
		'{16'h1125, 16'h0007, 16'h0180, 16'd256, 16'd129, 4'h7},
		'{16'h1137, 16'h0007, 16'h0100, 16'd1024, 16'd767, 4'h7}
	};

	timer16_wave u_timer16_wave (
		.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wave_pin(wave_pin), .wave_pin_oe(wave_pin_oe)
	);
	wave_load u_wave_load (
		.clk_sys(clk_sys), .wave_pin(wave_pin), .wave_pin_oe(wave_pin_oe), .pad(pad),
		.period(period), .high_len(high_len), .edges(edges)
	);

	always #12.5 clk_sys = ~clk_sys;

	task automatic results();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held from setup until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("[ERR] pready expected 1 seen timeout");
			results();
		end else begin
			rdata = prdata;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic apb_wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask

	task automatic apb_rd(input logic [7:0] addr, input logic [31:0] exp, input logic experr);
		apb(1'b0, addr, 32'h0);
		chk("pslverr", {31'h0, experr}, {31'h0, rerr});
		if (!experr) begin
			chk("prdata", exp, rdata);
		end
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("wave_pin_oe", 32'h0, {30'h0, wave_pin_oe});
		apb_rd(timer16_pkg::OFF_CTRL, 32'h0, 1'b0);
		apb_rd(timer16_pkg::OFF_FLAGS, 32'h0, 1'b0);
		apb_rd(8'h18, 32'h0, 1'b1);
		apb(1'b1, 8'h18, 32'hFFFF);
		chk("pslverr", 32'h1, {31'h0, rerr});
		foreach (cases[i]) begin
			apb_wr(timer16_pkg::OFF_CTRL, {16'h0, cases[i].ctrl & 16'h0FFF});
			apb_wr(timer16_pkg::OFF_COUNT, 32'h0);
			apb_wr(timer16_pkg::OFF_CAPTOP, {16'h0, cases[i].top});
			apb_wr(timer16_pkg::OFF_CMP_A, {16'h0, cases[i].cmp});
			apb_wr(timer16_pkg::OFF_FLAGS, 32'hF);
			apb_wr(timer16_pkg::OFF_CTRL, {16'h0, cases[i].ctrl});
			repeat (4 * cases[i].per + 20) @(posedge clk_sys);
			chk("period", {16'h0, cases[i].per}, {16'h0, period});
			chk("high_len", {16'h0, cases[i].hi}, {16'h0, high_len});
			apb_rd(timer16_pkg::OFF_FLAGS, {28'h0, cases[i].flags}, 1'b0);
		end
		apb_wr(timer16_pkg::OFF_CTRL, 32'h0F04);
		repeat (3) @(posedge clk_sys);
		chk("pad", 32'h3, {30'h0, pad});
		apb_wr(timer16_pkg::OFF_CTRL, 32'h0404);
		repeat (3) @(posedge clk_sys);
		chk("wave_pin_oe", 32'h0, {30'h0, wave_pin_oe});
		// top written below the count: the match is missed and the counter wraps first
		apb_wr(timer16_pkg::OFF_CTRL, 32'h000C);
		apb_wr(timer16_pkg::OFF_CAPTOP, 32'h0010);
		apb_wr(timer16_pkg::OFF_COUNT, 32'hFFF8);
		apb_wr(timer16_pkg::OFF_FLAGS, 32'hF);
		apb_wr(timer16_pkg::OFF_CTRL, 32'h100C);
		repeat (12) @(posedge clk_sys);
		apb_rd(timer16_pkg::OFF_FLAGS, 32'h5, 1'b0);
		apb_wr(timer16_pkg::OFF_CTRL, 32'h002E);
		apb_wr(timer16_pkg::OFF_COUNT, 32'h0);
		apb_wr(timer16_pkg::OFF_CAPTOP, 32'h0007);
		apb_wr(timer16_pkg::OFF_CMP_A, 32'h0007);
		apb_wr(timer16_pkg::OFF_CTRL, 32'h112E);
		repeat (40) @(posedge clk_sys);
		edges_seen = edges;
		repeat (40) @(posedge clk_sys);
		chk("edges", {16'h0, edges_seen}, {16'h0, edges});
		chk("pad", 32'h1, {30'h0, pad});
		apb_wr(timer16_pkg::OFF_CMP_A, 32'h0003);
		apb_rd(timer16_pkg::OFF_CMP_A, 32'h0003, 1'b0);
		repeat (40) @(posedge clk_sys);
		chk("high_len", 32'd4, {16'h0, high_len});
		apb_wr(timer16_pkg::OFF_CTRL, 32'h002E);
		apb_wr(timer16_pkg::OFF_COUNT, 32'h0055);
		repeat (10) @(posedge clk_sys);
		apb_rd(timer16_pkg::OFF_COUNT, 32'h0055, 1'b0);
		results();
	end
endmodule
`default_nettype wire
